// ===== hw/lerc_defs.svh
// Purpose: Offsets, field positions, reset values for the retry CSR block
// Assumes: Byte offsets are relative to the start of the capability
// Notes: Definitions only
`ifndef LERC_DEFS_SVH
`define LERC_DEFS_SVH

// Register byte offsets
`define LERC_OFF_HDR 8'h00
`define LERC_OFF_CTLSTAT 8'h04
`define LERC_OFF_COUNT 8'h08

// Header fields
`define LERC_CAP_ID 8'h08
`define LERC_CAP_TYPE 5'h18
`define LERC_NEXT_PTR_RST 8'h00

// Control field positions
`define LERC_CTL_RETRY_EN 0
`define LERC_CTL_FORCE_ERR 1
`define LERC_CTL_ROLL_NF 2
`define LERC_CTL_FORCE_STOMP 3
`define LERC_CTL_RETRY_NF 4
`define LERC_CTL_RETRY_FATAL 5
`define LERC_CTL_SHORT_LSB 6
`define LERC_CTL_SHORT_MSB 7

// Status field positions
`define LERC_ST_RETRY_SENT 0
`define LERC_ST_ROLLOVER 1
`define LERC_ST_STOMP_RCVD 2

// Reset values
`define LERC_SHORT_RST 2'h3
`define LERC_CTL_RST 8'h00
`define LERC_STAT_RST 8'h00
`define LERC_COUNT_RST 16'h0000
`define LERC_COUNT_MAX 16'hffff

`endif

// ===== hw/lerc_pkg.sv
// Purpose: Types shared by the retry CSR block and its users
// Assumes: Two link slots at most
// Notes: Constants live in lerc_defs.svh
package lerc_pkg;

  // Events reported by one link's retry and training logic
  typedef struct packed {
    logic retry_attempt;  // A retry was attempted
    logic train_timeout;  // Training timer expired on a link error
    logic retry_sent;     // Disconnect NOP sent to enter retry
    logic stomp_rcvd;     // Stomped packet received
    logic rx_retry_enter; // Receive side entered retry state
    logic err_forced;     // Forced CRC error has been sent
    logic stomp_forced;   // Forced stomp has been sent
  } lerc_evt_s;

  // Controls handed to one link's retry and training logic
  typedef struct packed {
    logic retry_mode;        // Retry mode in force since last warm reset
    logic force_err;         // Corrupt CRC of one packet
    logic force_stomp;       // Stomp one packet
    logic full_train_on_crc; // No short attempts: CRC error means full training
    logic [1:0] short_limit; // Allowed short retry attempts
  } lerc_ctl_s;

endpackage

// ===== hw/lerc_csr.sv
// Purpose: Error retry capability registers for up to two links
// Assumes: Config accesses are synchronous, one per request cycle
// Notes: rst_i is cold reset; warm_rst_i is a synchronous warm reset level
`timescale 1ns/1ns
`include "lerc_defs.svh"

// Notes on behaviour
// - Header byte 0 reads constant 08h
// - Header byte 1 is next capability pointer
// - Header bits 31:27 read type 11000b
// - Single-link device: link 1 bytes reserved
// - Retry enable takes effect at warm reset
// - AC-coupled link sets retry enable after cold
// - Force-error bit corrupts one packet, self-clears
// - Force-stomp bit stomps one packet, self-clears
// - Rollover nonfatal enable: interrupt on counter wrap
// - Retry nonfatal enable: interrupt on receive retry
// - Retry fatal enable: fatal interrupt on retry
// - Short attempts field, warm reset to 3
// - Zero short attempts forces full training
// - Retry-sent status, read clears, cold clears
// - Count-rollover status, read clears, cold clears
// - Stomp-received status, read clears, cold clears
// - 16-bit RW retry counter counts attempts, timeouts
// - Counter wraps FFFFh to 0000h, sets rollover
module lerc_csr
  import lerc_pkg::*;
#(
  parameter int NUM_LINKS = 2,                   // Links served, 1 or 2
  parameter logic [7:0] NEXT_PTR = `LERC_NEXT_PTR_RST // Next capability
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic warm_rst_i,
  input wire logic ac_coupled_i,
  input wire logic cfg_req_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  input wire lerc_evt_s [1:0] link_evt_i,
  output lerc_ctl_s [1:0] link_ctl_o,
  output logic [1:0] nonfatal_irq_o,
  output logic [1:0] fatal_irq_o
);

  // Refuse link counts the register layout cannot hold
  if (NUM_LINKS < 1 || NUM_LINKS > 2) begin : g_bad_links
    $error("lerc_csr: NUM_LINKS must be 1 or 2");
  end

  // Header word as read by software
  localparam logic [31:0] HDR_WORD = {`LERC_CAP_TYPE, 3'h0, 8'h00, NEXT_PTR, `LERC_CAP_ID};

  logic boot_q;                // Low only in the first cycle after cold reset
  logic [7:0] ctrl_q [2];      // Control byte per link
  logic [7:0] stat_q [2];      // Status byte per link
  logic [15:0] cnt_q [2];      // Retry counter per link
  logic [1:0] mode_q;          // Retry mode latched at warm reset
  logic [1:0] full_q;          // Full-training flag per link
  logic [1:0] nf_q;            // Nonfatal interrupt pulses
  logic [1:0] fat_q;           // Fatal interrupt pulses
  logic [1:0] roll_evt;        // Counter wraps this cycle
  logic [1:0] rd_st;           // Status byte read this cycle
  logic [31:0] rdata_q;        // Registered read data
  logic ack_q;                 // Registered acknowledge
  logic rd_any;                // Any read request
  logic wr_any;                // Any write request

  assign rd_any = cfg_req_i && !cfg_wr_i;
  assign wr_any = cfg_req_i && cfg_wr_i;

  // Marks the first clocked cycle after cold reset release
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_q <= 1'b0;
    end else begin
      boot_q <= 1'b1;
    end
  end

  // Per-link register slice
  for (genvar l = 0; l < 2; l++) begin : g_link
    localparam bit ON = (l < NUM_LINKS);
    lerc_evt_s evt;            // Events, silenced for an absent link
    logic wr_ctl;              // Control byte written
    logic wr_lo;               // Counter low byte written
    logic wr_hi;               // Counter high byte written
    logic inc;                 // Counter increments
    logic [7:0] wd;            // Write data for the control byte

    assign evt = ON ? link_evt_i[l] : '0;
    assign wd = cfg_wdata_i[8*(2*l) +: 8];
    assign wr_ctl = ON && wr_any && cfg_addr_i == `LERC_OFF_CTLSTAT && cfg_be_i[2*l];
    assign rd_st[l] = ON && rd_any && cfg_addr_i == `LERC_OFF_CTLSTAT && cfg_be_i[2*l+1];
    assign wr_lo = ON && wr_any && cfg_addr_i == `LERC_OFF_COUNT && cfg_be_i[2*l];
    assign wr_hi = ON && wr_any && cfg_addr_i == `LERC_OFF_COUNT && cfg_be_i[2*l+1];
    // Software write to the counter wins over an increment
    assign inc = (evt.retry_attempt || evt.train_timeout) && !wr_lo && !wr_hi;
    assign roll_evt[l] = inc && cnt_q[l] == `LERC_COUNT_MAX;

    // Control byte: warm reset, boot load, writes, self-clear of force bits
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        ctrl_q[l] <= `LERC_CTL_RST;
      end else if (warm_rst_i) begin
        // Retry enable survives warm reset; all else returns to default
        ctrl_q[l] <= `LERC_CTL_RST;
        // An absent link keeps its reserved byte at zero
        ctrl_q[l][`LERC_CTL_SHORT_MSB:`LERC_CTL_SHORT_LSB] <=
          ON ? `LERC_SHORT_RST : 2'h0;
        ctrl_q[l][`LERC_CTL_RETRY_EN] <= ctrl_q[l][`LERC_CTL_RETRY_EN];
      end else begin
        if (!boot_q) begin
          ctrl_q[l][`LERC_CTL_RETRY_EN] <= ON && ac_coupled_i;
        end
        // Link reports the forced fault went out
        if (evt.err_forced) begin
          ctrl_q[l][`LERC_CTL_FORCE_ERR] <= 1'b0;
        end
        if (evt.stomp_forced) begin
          ctrl_q[l][`LERC_CTL_FORCE_STOMP] <= 1'b0;
        end
        if (wr_ctl) begin
          ctrl_q[l][`LERC_CTL_RETRY_EN] <= wd[`LERC_CTL_RETRY_EN];
          ctrl_q[l][`LERC_CTL_ROLL_NF] <= wd[`LERC_CTL_ROLL_NF];
          ctrl_q[l][`LERC_CTL_RETRY_NF] <= wd[`LERC_CTL_RETRY_NF];
          ctrl_q[l][`LERC_CTL_RETRY_FATAL] <= wd[`LERC_CTL_RETRY_FATAL];
          ctrl_q[l][`LERC_CTL_SHORT_MSB:`LERC_CTL_SHORT_LSB] <=
            wd[`LERC_CTL_SHORT_MSB:`LERC_CTL_SHORT_LSB];
          // Force bits set on a one, a zero leaves them alone
          if (wd[`LERC_CTL_FORCE_ERR]) begin
            ctrl_q[l][`LERC_CTL_FORCE_ERR] <= 1'b1;
          end
          if (wd[`LERC_CTL_FORCE_STOMP]) begin
            ctrl_q[l][`LERC_CTL_FORCE_STOMP] <= 1'b1;
          end
        end
      end
    end

    // Retry mode and full-training flag seen by the link
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        mode_q[l] <= 1'b0;
        full_q[l] <= 1'b0;
      end else begin
        if (warm_rst_i) begin
          mode_q[l] <= ctrl_q[l][`LERC_CTL_RETRY_EN];
        end
        full_q[l] <= ON && ctrl_q[l][`LERC_CTL_SHORT_MSB:`LERC_CTL_SHORT_LSB] == 2'h0;
      end
    end

    // Status byte: sticky, read clears, a new event wins over the clear
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        stat_q[l] <= `LERC_STAT_RST;
      end else begin
        if (rd_st[l]) begin
          stat_q[l] <= `LERC_STAT_RST;
        end
        if (evt.retry_sent) begin
          stat_q[l][`LERC_ST_RETRY_SENT] <= 1'b1;
        end
        if (roll_evt[l]) begin
          stat_q[l][`LERC_ST_ROLLOVER] <= 1'b1;
        end
        if (evt.stomp_rcvd) begin
          stat_q[l][`LERC_ST_STOMP_RCVD] <= 1'b1;
        end
      end
    end

    // Retry counter, cold reset only, wraps naturally at 16 bits
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        cnt_q[l] <= `LERC_COUNT_RST;
      end else begin
        if (wr_lo) begin
          cnt_q[l][7:0] <= cfg_wdata_i[16*l +: 8];
        end
        if (wr_hi) begin
          cnt_q[l][15:8] <= cfg_wdata_i[16*l+8 +: 8];
        end
        if (inc) begin
          cnt_q[l] <= cnt_q[l] + 16'h0001;
        end
      end
    end

    // Interrupt requests, one pulse per qualifying cycle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        nf_q[l] <= 1'b0;
        fat_q[l] <= 1'b0;
      end else begin
        nf_q[l] <= (ctrl_q[l][`LERC_CTL_ROLL_NF] && roll_evt[l])
                   || (ctrl_q[l][`LERC_CTL_RETRY_NF] && evt.rx_retry_enter);
        fat_q[l] <= ctrl_q[l][`LERC_CTL_RETRY_FATAL] && evt.rx_retry_enter;
      end
    end

    // Link-facing controls, all from flops
    assign link_ctl_o[l].retry_mode = mode_q[l];
    assign link_ctl_o[l].force_err = ctrl_q[l][`LERC_CTL_FORCE_ERR];
    assign link_ctl_o[l].force_stomp = ctrl_q[l][`LERC_CTL_FORCE_STOMP];
    assign link_ctl_o[l].full_train_on_crc = full_q[l];
    assign link_ctl_o[l].short_limit = ctrl_q[l][`LERC_CTL_SHORT_MSB:`LERC_CTL_SHORT_LSB];
  end

  // Read mux and acknowledge, one cycle after the request
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else begin
      ack_q <= cfg_req_i;
      if (rd_any) begin
        case (cfg_addr_i)
          `LERC_OFF_HDR: rdata_q <= HDR_WORD;
          `LERC_OFF_CTLSTAT: rdata_q <= {stat_q[1], ctrl_q[1], stat_q[0], ctrl_q[0]};
          `LERC_OFF_COUNT: rdata_q <= {cnt_q[1], cnt_q[0]};
          // Unmapped offsets read as zero
          default: rdata_q <= 32'h0000_0000;
        endcase
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  assign cfg_rdata_o = rdata_q;
  assign cfg_ack_o = ack_q;
  assign nonfatal_irq_o = nf_q;
  assign fatal_irq_o = fat_q;

  // Checks on link 0 behaviour, and on the reserved link 1 of a single-link device
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // Header read request and its answer
  sequence s_hdr_rd;
    rd_any && cfg_addr_i == `LERC_OFF_HDR;
  endsequence
  property p_hdr;
    s_hdr_rd |=> cfg_ack_o && cfg_rdata_o[7:0] == 8'h08 && cfg_rdata_o[31:27] == 5'h18
                 && cfg_rdata_o[15:8] == NEXT_PTR;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header read wrong");

  property p_reserved;
    (NUM_LINKS == 1) |-> ctrl_q[1] == 8'h00 && stat_q[1] == 8'h00 && cnt_q[1] == 16'h0000
                         && !nonfatal_irq_o[1] && !fatal_irq_o[1];
  endproperty
  a_reserved: assert property (p_reserved) else $error("link 1 not reserved");

  property p_mode;
    warm_rst_i |=> link_ctl_o[0].retry_mode == $past(ctrl_q[0][0]);
  endproperty
  a_mode: assert property (p_mode) else $error("retry mode not taken");

  property p_warm;
    warm_rst_i |=> ctrl_q[0][7:6] == 2'h3 && ctrl_q[0][5:1] == 5'h00;
  endproperty
  a_warm: assert property (p_warm) else $error("warm reset defaults");

  // Force bit raised, then served by the link
  sequence s_err_served;
    ctrl_q[0][1] && link_evt_i[0].err_forced && !g_link[0].wr_ctl && !warm_rst_i;
  endsequence
  property p_force;
    s_err_served |=> !link_ctl_o[0].force_err;
  endproperty
  a_force: assert property (p_force) else $error("force error not cleared");

  property p_stomp;
    ctrl_q[0][3] && !link_evt_i[0].stomp_forced && !warm_rst_i |=> ctrl_q[0][3];
  endproperty
  a_stomp: assert property (p_stomp) else $error("stomp bit lost early");

  property p_fatal;
    fatal_irq_o[0] |-> $past(ctrl_q[0][5]) && $past(link_evt_i[0].rx_retry_enter);
  endproperty
  a_fatal: assert property (p_fatal) else $error("fatal irq without cause");

  property p_nf;
    ctrl_q[0][4] && link_evt_i[0].rx_retry_enter |=> nonfatal_irq_o[0];
  endproperty
  a_nf: assert property (p_nf) else $error("nonfatal irq missing");

  // Wrap of the counter and its effects
  property p_wrap;
    roll_evt[0] |=> cnt_q[0] == 16'h0000 && stat_q[0][1]
                    && (nonfatal_irq_o[0] == $past(ctrl_q[0][2]) || $past(ctrl_q[0][4]));
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter wrap wrong");

  property p_rc;
    rd_st[0] && !link_evt_i[0].retry_sent && !link_evt_i[0].stomp_rcvd && !roll_evt[0]
      |=> stat_q[0] == 8'h00;
  endproperty
  a_rc: assert property (p_rc) else $error("status not cleared by read");

  property p_full;
    ctrl_q[0][7:6] == 2'h0 ##1 ctrl_q[0][7:6] == 2'h0 |-> link_ctl_o[0].full_train_on_crc;
  endproperty
  a_full: assert property (p_full) else $error("full training flag missing");

  property p_boot;
    !boot_q |=> ctrl_q[0][0] == $past(ac_coupled_i) || $past(warm_rst_i)
                || $past(g_link[0].wr_ctl);
  endproperty
  a_boot: assert property (p_boot) else $error("ac coupled boot load");

  property p_keep_en;
    warm_rst_i |=> ctrl_q[0][0] == $past(ctrl_q[0][0]);
  endproperty
  a_keep_en: assert property (p_keep_en) else $error("retry enable lost on warm");

  // Link events land in the sticky status bits, set beats read clear
  property p_sent;
    link_evt_i[0].retry_sent |=> stat_q[0][0];
  endproperty
  a_sent: assert property (p_sent) else $error("retry sent status missing");

  property p_stomp_rcvd;
    link_evt_i[0].stomp_rcvd |=> stat_q[0][2];
  endproperty
  a_stomp_rcvd: assert property (p_stomp_rcvd) else $error("stomp status missing");

  // A retry with no counter write in the way adds one
  property p_inc;
    link_evt_i[0].retry_attempt && !wr_any |=> cnt_q[0] == $past(cnt_q[0]) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("retry count did not step");

  // Wrap with the rollover enable set gives a nonfatal pulse
  sequence s_wrap_armed;
    link_evt_i[0].retry_attempt && !wr_any && cnt_q[0] == 16'hffff && ctrl_q[0][2];
  endsequence
  property p_roll_irq;
    s_wrap_armed |=> nonfatal_irq_o[0];
  endproperty
  a_roll_irq: assert property (p_roll_irq) else $error("rollover interrupt missing");

endmodule

// ===== sim/lerc_csr_tb_top.sv
// Purpose: Self-checking bench for the retry CSR block, two-link and one-link copies
// Assumes: Inputs change on the falling edge; reads are checked from a queue
// Notes: Monitor pops one note per ack; write notes carry no compare
`timescale 1ns/1ns
module lerc_csr_tb_top
  import lerc_pkg::*;
;
  logic sys_clk_i;                 // 25 MHz clock
  logic rst_i;                     // Cold reset
  logic warm_rst_i;                // Warm reset level
  logic ac_coupled_i;              // Boot value of retry enable
  logic cfg_req_i, cfg_wr_i;       // Config request and direction
  logic [7:0] cfg_addr_i;          // Byte offset
  logic [3:0] cfg_be_i;            // Byte enables
  logic [31:0] cfg_wdata_i;        // Write data
  logic [31:0] cfg_rdata_o;        // Read data
  logic cfg_ack_o;                 // Access answer
  lerc_evt_s [1:0] link_evt;       // Link event pulses
  lerc_ctl_s [1:0] link_ctl;       // Controls to the links
  logic [1:0] nf_irq, fat_irq;     // Interrupt pulses
  logic [31:0] one_rdata;          // Single-link copy read data
  lerc_ctl_s [1:0] one_ctl;        // Single-link copy controls
  logic [1:0] one_nf, one_fat;     // Single-link copy interrupts
  logic [33:0] exq[$];             // Notes: {compare, header, expected}
  int fails = 0;                   // Mismatches
  int checks_done = 0;             // Compares made
  int seed = 32'h73b4;             // Random seed
  logic [15:0] rnd;                // Random counter value

  lerc_csr i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .warm_rst_i(warm_rst_i),
    .ac_coupled_i(ac_coupled_i), .cfg_req_i(cfg_req_i), .cfg_wr_i(cfg_wr_i),
    .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o), .link_evt_i(link_evt),
    .link_ctl_o(link_ctl), .nonfatal_irq_o(nf_irq), .fatal_irq_o(fat_irq));

  // Same stimulus into a single-link copy; its link 1 slots stay reserved
  lerc_csr #(.NUM_LINKS(1)) i_dut_one (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .warm_rst_i(warm_rst_i), .ac_coupled_i(ac_coupled_i), .cfg_req_i(cfg_req_i),
    .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(one_rdata), .cfg_ack_o(),
    .link_evt_i(link_evt), .link_ctl_o(one_ctl), .nonfatal_irq_o(one_nf),
    .fatal_irq_o(one_fat));

  // Free-running clock
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One config access; request stays up for back-to-back use
  task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d, input logic [31:0] exp);
    cfg_req_i = 1'b1;
    cfg_wr_i = wr;
    cfg_addr_i = a;
    cfg_be_i = be;
    cfg_wdata_i = d;
    exq.push_back({~wr, a == 8'h00, exp});
    @(negedge sys_clk_i);
  endtask

  // Drop the request and let cycles pass
  task automatic quiet(input int n);
    cfg_req_i = 1'b0;
    repeat (n) @(negedge sys_clk_i);
  endtask

  // One warm reset cycle
  task automatic warm();
    warm_rst_i = 1'b1;
    @(negedge sys_clk_i);
    warm_rst_i = 1'b0;
    @(negedge sys_clk_i);
  endtask

  // One event pulse, then interrupt pulse seen for exactly one cycle
  task automatic ev(input int l, input logic [6:0] e, input logic [1:0] nf,
                    input logic [1:0] fat);
    link_evt[l] = lerc_evt_s'(e);
    @(negedge sys_clk_i);
    link_evt[l] = '0;
    chk({30'h0, nf_irq}, {30'h0, nf});
    chk({30'h0, fat_irq}, {30'h0, fat});
    chk({28'h0, one_nf, one_fat}, {28'h0, 1'b0, nf[0], 1'b0, fat[0]});
    @(negedge sys_clk_i);
    chk({28'h0, nf_irq, fat_irq}, 32'h0);
  endtask

  // Verdict, reached from the main sequence or the watchdog
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Monitor: each ack takes the oldest note
  always @(negedge sys_clk_i) begin
    if (cfg_ack_o === 1'b1) begin
      if (exq.size() == 0) begin
        chk(32'h1, 32'h0);
      end else if (exq[0][33]) begin
        chk(cfg_rdata_o, exq[0][31:0]);
        chk(one_rdata, exq[0][32] ? exq[0][31:0] : {16'h0, exq[0][15:0]});
        void'(exq.pop_front());
      end else begin
        void'(exq.pop_front());
      end
    end
  end

  // Watchdog well beyond the sequence length
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    fails++;
    end_of_test();
  end

  // Main sequence
  initial begin
    rst_i = 1'b1;
    warm_rst_i = 1'b0;
    ac_coupled_i = 1'b1;
    cfg_req_i = 1'b0;
    cfg_wr_i = 1'b0;
    cfg_addr_i = 8'h00;
    cfg_be_i = 4'h0;
    cfg_wdata_i = 32'h0;
    link_evt = '0;
    repeat (20) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    acc(1'b0, 8'h04, 4'hf, 32'h0, 32'h00010001);
    acc(1'b0, 8'h00, 4'hf, 32'h0, {5'h18, 11'h0, 8'h00, 8'h08});
    acc(1'b1, 8'h00, 4'hf, 32'hffffffff, 32'h0);
    acc(1'b0, 8'h00, 4'hf, 32'h0, {5'h18, 11'h0, 8'h00, 8'h08});
    acc(1'b0, 8'h0c, 4'hf, 32'h0, 32'h0);
    quiet(1);
    warm();
    chk({31'h0, link_ctl[0].retry_mode}, 32'h1);
    chk({30'h0, link_ctl[1].short_limit}, 32'h3);
    acc(1'b1, 8'h04, 4'h1, 32'h000000c0, 32'h0);
    acc(1'b0, 8'h04, 4'hf, 32'h0, 32'h00c100c0);
    quiet(1);
    chk({31'h0, link_ctl[0].retry_mode}, 32'h1);
    warm();
    chk({31'h0, link_ctl[0].retry_mode}, 32'h0);
    acc(1'b1, 8'h04, 4'h1, 32'h00000004, 32'h0);
    quiet(2);
    chk({31'h0, link_ctl[0].full_train_on_crc}, 32'h1);
    rnd = 16'($random(seed));
    acc(1'b1, 8'h08, 4'hf, {rnd, 16'hffff}, 32'h0);
    acc(1'b0, 8'h08, 4'hf, 32'h0, {rnd, 16'hffff});
    quiet(1);
    ev(0, 7'h40, 2'b01, 2'b00);
    acc(1'b0, 8'h08, 4'hf, 32'h0, {rnd, 16'h0000});
    acc(1'b0, 8'h04, 4'hf, 32'h0, 32'h00c10204);
    acc(1'b0, 8'h04, 4'hf, 32'h0, 32'h00c10004);
    quiet(1);
    ev(0, 7'h20, 2'b00, 2'b00);
    acc(1'b0, 8'h08, 4'hf, 32'h0, {rnd, 16'h0001});
    acc(1'b1, 8'h04, 4'h5, 32'h00f00034, 32'h0);
    quiet(1);
    ev(1, 7'h04, 2'b10, 2'b10);
    ev(0, 7'h04, 2'b01, 2'b01);
    ev(1, 7'h18, 2'b00, 2'b00);
    ev(0, 7'h18, 2'b00, 2'b00);
    acc(1'b0, 8'h04, 4'hf, 32'h0, 32'h05f00534);
    acc(1'b0, 8'h04, 4'hf, 32'h0, 32'h00f00034);
    acc(1'b1, 8'h04, 4'h1, 32'h0000000e, 32'h0);
    quiet(1);
    chk({30'h0, link_ctl[0].force_err, link_ctl[0].force_stomp}, 32'h3);
    ev(0, 7'h02, 2'b00, 2'b00);
    chk({30'h0, link_ctl[0].force_err, link_ctl[0].force_stomp}, 32'h1);
    ev(0, 7'h01, 2'b00, 2'b00);
    chk({30'h0, link_ctl[0].force_err, link_ctl[0].force_stomp}, 32'h0);
    acc(1'b0, 8'h04, 4'h1, 32'h0, 32'h00f00004);
    quiet(1);
    warm();
    acc(1'b0, 8'h04, 4'hf, 32'h0, 32'h00c000c0);
    quiet(3);
    chk(32'(one_ctl[1]), 32'h0);
    chk(32'(exq.size()), 32'h0);
    end_of_test();
  end
endmodule
